/* rtl/macrocell_pkg.sv */
// Shared widths, selector encodings and sizes for the logic macrocell.
// Assumes one 20 MHz system clock; all option selects are static setup.
package macrocell_pkg;

    // ==========================================================
    // Widths and counts
    localparam int PIN_W      = 32;  // Input and I/O pins on the global bus
    localparam int FB_W       = 64;  // Buried feedbacks, one per macrocell
    localparam int GBUS_W     = PIN_W + FB_W;
    localparam int BLOCK_IN_W = 40;  // Switch matrix outputs per logic block
    localparam int REGION_W   = 16;  // Foldback terms in a region
    localparam int LIT_W      = BLOCK_IN_W + REGION_W;
    localparam int PT_N       = 5;   // Product terms per macrocell
    localparam int PT_IDX_W   = 3;
    localparam int GCLK_N     = 3;   // Global clock lines 0 to 2
    localparam int OE_PIN_N   = 2;
    localparam int MSEL_W     = 7;   // Switch matrix select width
    localparam int SYNC_W     = PIN_W + GCLK_N + 1 + OE_PIN_N + 2;
    localparam int CLK_HZ     = 20_000_000;

    // Reset values
    localparam logic Q_RESET  = 1'b0;
    localparam logic OE_N_OFF = 1'b1;

    // ==========================================================
    // Selector encodings
    typedef enum logic [1:0] {XB_PT, XB_HIGH, XB_LOW} xor_b_type;
    typedef enum logic [1:0] {DATA_XOR, DATA_PT, DATA_PIN} data_src_type;
    typedef enum logic [2:0] {FF_D, FF_T, FF_JK, FF_SR, FF_LATCH} ff_mode_type;
    typedef enum logic [1:0] {CLR_GLOBAL, CLR_PT, CLR_BOTH, CLR_OFF} clear_sel_type;
    typedef enum logic {SET_PT, SET_OFF} set_sel_type;
    typedef enum logic [2:0] {
        OE_ALWAYS, OE_NEVER, OE_PIN0, OE_PIN1, OE_IO_PIN, OE_PT
    } oe_sel_type;

endpackage : macrocell_pkg

/* rtl/input_sync.sv */
// Three-stage synchroniser with an agreement filter for pin inputs.
// Assumes inputs are asynchronous to clk_in; output changes only once
// the second and third stages agree.
`timescale 1ns/1ps
module input_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    // Pins
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level_out
);
    import macrocell_pkg::*;

    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;
    logic [W-1:0] stage3_reg;

    // ==========================================================
    // Stage chain; stage one feeds only stage two
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // Filter: a bit moves only when the last two stages agree
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            level_out <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (stage2_reg[i] == stage3_reg[i]) begin
                    level_out[i] <= stage3_reg[i];
                end
            end
        end
    end

endmodule : input_sync

/* rtl/product_term_array.sv */
// AND array producing the five product terms of one macrocell.
// Assumes literal inputs are already in the clk_in domain.
`timescale 1ns/1ps
module product_term_array (
    // Literals from the block inputs and the regional bus
    input  wire logic [macrocell_pkg::LIT_W-1:0] lit_in,
    // Per-term true and complement literal masks (static)
    input  wire logic [macrocell_pkg::LIT_W-1:0] true_mask_in [macrocell_pkg::PT_N],
    input  wire logic [macrocell_pkg::LIT_W-1:0] comp_mask_in [macrocell_pkg::PT_N],
    // Product terms
    output logic      [macrocell_pkg::PT_N-1:0]  term_out
);
    import macrocell_pkg::*;

    // ==========================================================
    // A term with no literal connected reads low, so an unused term
    // never adds a stray one into the sum
    always_comb begin
        for (int t = 0; t < PT_N; t++) begin
            term_out[t] = (|(true_mask_in[t] | comp_mask_in[t]))
                        & (&(~true_mask_in[t] | lit_in))
                        & (&(~comp_mask_in[t] | ~lit_in));
        end
    end

endmodule : product_term_array

/* rtl/programmable_macrocell.sv */
// One configurable logic macrocell: switch matrix, product terms,
// OR/XOR/cascade sum, multi-mode storage element and output select.
// Assumes all cfg_* ports are held static while running and pins reach
// this block asynchronously; everything runs on clk_in.
//
// Operation
// - Five product terms, each reading the global and regional buses.
// - Term select mux sends each term to logic gates or control.
// - OR sums up to five terms; chain input extends to forty.
// - XOR second input is a term, high or low for polarity.
// - Register data from XOR output, separate term, or own pin.
// - Separate term data gives buried register beside combinational pin.
// - Storage acts as D, T, JK, SR, or latch open while clock high.
// - Register clock is global line 0, 1, 2 or a term.
// - Outside latch mode, clocked updates happen only on rising edge of its chosen clock.
// - With global clock, a low enable term makes edges ignored.
// - Clear is global clear, a term, their OR, or off.
// - Set is a term or off.
// - Pin output is registered value or combinational XOR.
// - Feedback registered or combinational, independent of pin choice.
// - Enable: always, never, either enable pin, I/O pin, or term.
// - Global bus holds pins and 64 feedbacks; matrix picks forty.
// - Foldback is an inverted term; sixteen combine into wide sums.
// - Sleep mode freezes pin inputs; sleep pin carries no logic.
// - Per-macrocell power-down option for unused cells.
// - Reset initialises registers; pin output takes its polarity level, bus outputs go low.
`timescale 1ns/1ps
module programmable_macrocell (
    // Clock and reset
    input  wire logic                                clk_in,
    input  wire logic                                rst_n_in,
    // Pins and buses
    input  wire logic [macrocell_pkg::PIN_W-1:0]     pins_in,
    input  wire logic [macrocell_pkg::FB_W-1:0]      feedback_bus_in,
    input  wire logic [macrocell_pkg::REGION_W-1:0]  foldback_bus_in,
    input  wire logic [macrocell_pkg::GCLK_N-1:0]    global_clock_line_in,
    input  wire logic                                global_clear_line_in,
    input  wire logic [macrocell_pkg::OE_PIN_N-1:0]  oe_pins_in,
    input  wire logic                                oe_io_pin_in,
    input  wire logic                                sleep_pin_in,
    input  wire logic                                chain_sum_in,
    // Own two-way pin
    input  wire logic                                io_in,
    output logic                                     io_out,
    output logic                                     io_oe_n_out,
    // Outputs to buses
    output logic                                     buried_fb_out,
    output logic                                     foldback_out,
    output logic                                     chain_sum_out,
    // Static configuration, fixed while running
    input  wire logic [macrocell_pkg::MSEL_W-1:0]    cfg_matrix_sel_in [macrocell_pkg::BLOCK_IN_W],
    input  wire logic [macrocell_pkg::LIT_W-1:0]     cfg_true_mask_in  [macrocell_pkg::PT_N],
    input  wire logic [macrocell_pkg::LIT_W-1:0]     cfg_comp_mask_in  [macrocell_pkg::PT_N],
    input  wire logic [macrocell_pkg::PT_N-1:0]      cfg_term_to_logic_in,
    input  wire logic                                cfg_chain_en_in,
    input  wire macrocell_pkg::xor_b_type            cfg_xor_b_in,
    input  wire macrocell_pkg::data_src_type         cfg_data_src_in,
    input  wire macrocell_pkg::ff_mode_type          cfg_ff_mode_in,
    input  wire logic                                cfg_clk_from_term_in,
    input  wire logic [1:0]                          cfg_clk_line_in,
    input  wire logic                                cfg_clk_enable_en_in,
    input  wire macrocell_pkg::clear_sel_type        cfg_clear_sel_in,
    input  wire macrocell_pkg::set_sel_type          cfg_set_sel_in,
    input  wire logic                                cfg_pin_registered_in,
    input  wire logic                                cfg_fb_registered_in,
    input  wire macrocell_pkg::oe_sel_type           cfg_oe_sel_in,
    input  wire logic [macrocell_pkg::PT_IDX_W-1:0]  cfg_idx_xor_b_in,
    input  wire logic [macrocell_pkg::PT_IDX_W-1:0]  cfg_idx_data_in,
    input  wire logic [macrocell_pkg::PT_IDX_W-1:0]  cfg_idx_aux_in,
    input  wire logic [macrocell_pkg::PT_IDX_W-1:0]  cfg_idx_clk_in,
    input  wire logic [macrocell_pkg::PT_IDX_W-1:0]  cfg_idx_ce_in,
    input  wire logic [macrocell_pkg::PT_IDX_W-1:0]  cfg_idx_clear_in,
    input  wire logic [macrocell_pkg::PT_IDX_W-1:0]  cfg_idx_set_in,
    input  wire logic [macrocell_pkg::PT_IDX_W-1:0]  cfg_idx_oe_in,
    input  wire logic [macrocell_pkg::PT_IDX_W-1:0]  cfg_idx_fold_in,
    input  wire logic                                cfg_sleep_en_in,
    input  wire logic                                cfg_is_sleep_pin_in,
    input  wire logic                                cfg_power_down_in,
    // Status
    output logic                                     q_out
);
    import macrocell_pkg::*;

    // ==========================================================
    // Helper functions

    // Control tap: a term claimed by the logic gates is not a control
    function automatic logic ctl_term(input logic [PT_N-1:0] pt,
                                      input logic [PT_N-1:0] to_logic,
                                      input logic [PT_IDX_W-1:0] idx);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < PT_N; i++) begin
            if (idx == PT_IDX_W'(i)) begin
                hit = pt[i] & ~to_logic[i];
            end
        end
        return hit;
    endfunction : ctl_term

    // Switch matrix pick; codes past the bus width read low
    function automatic logic bus_pick(input logic [GBUS_W-1:0] bus,
                                      input logic [MSEL_W-1:0] sel);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < GBUS_W; i++) begin
            if (sel == MSEL_W'(i)) begin
                hit = bus[i];
            end
        end
        return hit;
    endfunction : bus_pick

    // ==========================================================
    // Pin synchronisation and sleep freeze
    logic [SYNC_W-1:0] sync_lvl;
    logic [SYNC_W-1:0] held_reg;
    logic              sleep_lvl;
    logic              asleep;

    input_sync #(.W(SYNC_W)) u_pin_sync (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .async_in  ({io_in, oe_io_pin_in, oe_pins_in, global_clear_line_in,
                     global_clock_line_in, pins_in}),
        .level_out (sync_lvl)
    );

    input_sync #(.W(1)) u_sleep_sync (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .async_in  (sleep_pin_in),
        .level_out (sleep_lvl)
    );

    assign asleep = cfg_sleep_en_in & sleep_lvl;

    // Pin levels freeze while asleep so no toggle reaches the array
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            held_reg <= '0;
        end else if (!asleep) begin
            held_reg <= sync_lvl;
        end
    end

    logic [PIN_W-1:0]    pin_lvl;
    logic [GCLK_N-1:0]   gclk_lvl;
    logic                global_clear_line_lvl;
    logic [OE_PIN_N-1:0] oe_pin_lvl;
    logic                oe_io_lvl;
    logic                io_lvl;

    assign {io_lvl, oe_io_lvl, oe_pin_lvl, global_clear_line_lvl, gclk_lvl, pin_lvl} = held_reg;

    // ==========================================================
    // Switch matrix and product terms
    logic [BLOCK_IN_W-1:0] block_in;
    logic [PT_N-1:0]       pt;

    // Feedbacks come from same-clock logic and need no synchroniser
    always_comb begin
        for (int b = 0; b < BLOCK_IN_W; b++) begin
            block_in[b] = bus_pick({feedback_bus_in, pin_lvl},
                                   cfg_matrix_sel_in[b]);
        end
    end

    product_term_array u_terms (
        .lit_in       ({foldback_bus_in, block_in}),
        .true_mask_in (cfg_true_mask_in),
        .comp_mask_in (cfg_comp_mask_in),
        .term_out     (pt)
    );

    // ==========================================================
    // Sum, chain and XOR
    logic sum_or;
    logic xor_b;
    logic xor_out;
    logic pin_data;

    assign sum_or = |(pt & cfg_term_to_logic_in)
                  | (cfg_chain_en_in & chain_sum_in);

    // A fixed level on the second input sets output polarity
    always_comb begin
        unique case (cfg_xor_b_in)
            XB_PT:   xor_b = ctl_term(pt, cfg_term_to_logic_in, cfg_idx_xor_b_in);
            XB_HIGH: xor_b = 1'b1;
            XB_LOW:  xor_b = 1'b0;
            default: xor_b = 1'b0;
        endcase
    end

    assign xor_out  = sum_or ^ xor_b;
    assign pin_data = cfg_is_sleep_pin_in ? 1'b0 : io_lvl;

    // ==========================================================
    // Register controls
    logic d_val;
    logic aux_val;
    logic clk_sel;
    logic clk_prev_reg;
    logic clk_rise;
    logic ce_ok;
    logic clear_act;
    logic set_act;
    logic q_reg;
    logic q_next;
    logic clear_hold_reg;

    // Data source; the separate term keeps the XOR free for the pin
    always_comb begin
        unique case (cfg_data_src_in)
            DATA_XOR: d_val = xor_out;
            DATA_PT:  d_val = ctl_term(pt, cfg_term_to_logic_in,
                                       cfg_idx_data_in);
            DATA_PIN: d_val = pin_data;
            default:  d_val = xor_out;
        endcase
    end

    assign aux_val = ctl_term(pt, cfg_term_to_logic_in, cfg_idx_aux_in);

    assign clk_sel = cfg_clk_from_term_in
                   ? ctl_term(pt, cfg_term_to_logic_in, cfg_idx_clk_in)
                   : (cfg_clk_line_in < 2'(GCLK_N)
                      && gclk_lvl[cfg_clk_line_in]);

    // Edge detector on the chosen clock; it runs off filtered levels
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            clk_prev_reg <= 1'b0;
        end else begin
            clk_prev_reg <= clk_sel;
        end
    end

    assign clk_rise = clk_sel & ~clk_prev_reg;

    // The enable term only applies with a global clock source
    assign ce_ok = cfg_clk_from_term_in || !cfg_clk_enable_en_in
                || ctl_term(pt, cfg_term_to_logic_in, cfg_idx_ce_in);

    always_comb begin
        unique case (cfg_clear_sel_in)
            CLR_GLOBAL: clear_act = global_clear_line_lvl;
            CLR_PT:     clear_act = ctl_term(pt, cfg_term_to_logic_in, cfg_idx_clear_in);
            CLR_BOTH:   clear_act = global_clear_line_lvl
                                  | ctl_term(pt, cfg_term_to_logic_in, cfg_idx_clear_in);
            CLR_OFF:    clear_act = 1'b0;
        endcase
    end

    assign set_act = (cfg_set_sel_in == SET_PT)
                   && ctl_term(pt, cfg_term_to_logic_in, cfg_idx_set_in);

    // Clocked update for each storage mode; all use the chosen data source, JK and SR take K and R from the aux term
    always_comb begin
        q_next = q_reg;
        unique case (cfg_ff_mode_in)
            FF_D:     q_next = d_val;
            FF_T:     q_next = q_reg ^ d_val;
            FF_JK:    q_next = (d_val & ~q_reg) | (~aux_val & q_reg);
            FF_SR:    q_next = (d_val & ~aux_val) ? 1'b1
                             : (aux_val & ~d_val) ? 1'b0 : q_reg;
            FF_LATCH: q_next = d_val;
            default:  q_next = q_reg;
        endcase
    end

    // Clear met by set: the cell stays at zero until set lets go as well,
    // so dropping clear first never lets set sneak a one in
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            clear_hold_reg <= 1'b0;
        end else begin
            clear_hold_reg <= (clear_act | clear_hold_reg) & set_act;
        end
    end

    // Storage element; clear wins over set, and power-down parks it
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q_reg <= Q_RESET;
        end else if (cfg_power_down_in) begin
            q_reg <= Q_RESET;
        end else if (clear_act || clear_hold_reg) begin
            q_reg <= 1'b0;
        end else if (set_act) begin
            q_reg <= 1'b1;
        end else if (cfg_ff_mode_in == FF_LATCH) begin
            if (clk_sel && ce_ok) begin
                q_reg <= q_next;
            end
        end else if (clk_rise && ce_ok) begin
            q_reg <= q_next;
        end
    end

    assign q_out = q_reg;

    // ==========================================================
    // Outputs and enable
    logic oe_want;

    always_comb begin
        unique case (cfg_oe_sel_in)
            OE_ALWAYS: oe_want = 1'b1;
            OE_NEVER:  oe_want = 1'b0;
            OE_PIN0:   oe_want = oe_pin_lvl[0];
            OE_PIN1:   oe_want = oe_pin_lvl[1];
            OE_IO_PIN: oe_want = oe_io_lvl;
            OE_PT:     oe_want = ctl_term(pt, cfg_term_to_logic_in, cfg_idx_oe_in);
            default:   oe_want = 1'b0;
        endcase
    end

    // Reset drives the polarity level; a low fixed XOR input reads 0
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            io_out      <= (cfg_xor_b_in == XB_HIGH);
            io_oe_n_out <= OE_N_OFF;
        end else begin
            io_out      <= cfg_pin_registered_in ? q_reg : xor_out;
            io_oe_n_out <= ~(oe_want & ~cfg_is_sleep_pin_in
                             & ~cfg_power_down_in);
        end
    end

    // Bus outputs; a powered-down cell feeds zeros everywhere
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || cfg_power_down_in) begin
            buried_fb_out <= 1'b0;
            foldback_out  <= 1'b0;
            chain_sum_out <= 1'b0;
        end else begin
            buried_fb_out <= cfg_fb_registered_in ? q_reg : xor_out;
            foldback_out  <= ~pt[cfg_idx_fold_in];
            chain_sum_out <= sum_or;
        end
    end

    // ==========================================================
    // Assertions
    logic normal;
    assign normal = !cfg_power_down_in && !clear_act && !clear_hold_reg && !set_act;

    property p_clear_wins;
        @(posedge clk_in) disable iff (!rst_n_in)
        clear_act |=> !q_reg;
    endproperty
    a_clear_wins: assert property (p_clear_wins) else $error("clear did not force zero");

    property p_set_only;
        @(posedge clk_in) disable iff (!rst_n_in)
        (set_act && !clear_act && !clear_hold_reg && !cfg_power_down_in) |=> q_reg;
    endproperty
    a_set_only: assert property (p_set_only) else $error("set did not force one");

    property p_edge_only;
        @(posedge clk_in) disable iff (!rst_n_in)
        (normal && cfg_ff_mode_in != FF_LATCH && !clk_rise) |=> $stable(q_reg);
    endproperty
    a_edge_only: assert property (p_edge_only) else $error("register moved without edge");

    property p_ce_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        (normal && !ce_ok) |=> $stable(q_reg);
    endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("disabled edge changed register");

    property p_d_capture;
        @(posedge clk_in) disable iff (!rst_n_in)
        (normal && cfg_ff_mode_in == FF_D && clk_rise && ce_ok) |=> q_reg == $past(d_val);
    endproperty
    a_d_capture: assert property (p_d_capture) else $error("D capture wrong");

    property p_pin_select;
        @(posedge clk_in) disable iff (!rst_n_in)
        1'b1 |=> io_out == ($past(cfg_pin_registered_in) ? $past(q_reg) : $past(xor_out));
    endproperty
    a_pin_select: assert property (p_pin_select) else $error("pin output select wrong");

    property p_oe_never;
        @(posedge clk_in) disable iff (!rst_n_in)
        (cfg_oe_sel_in == OE_NEVER) |=> io_oe_n_out;
    endproperty
    a_oe_never: assert property (p_oe_never) else $error("pin driven while disabled");

    property p_power_down;
        @(posedge clk_in) disable iff (!rst_n_in)
        cfg_power_down_in [*2] |-> !q_reg && !buried_fb_out && io_oe_n_out;
    endproperty
    a_power_down: assert property (p_power_down) else $error("powered-down cell active");

    property p_sleep_freeze;
        @(posedge clk_in) disable iff (!rst_n_in)
        asleep |=> $stable(held_reg);
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze) else $error("pins moved while asleep");

    property p_fold_inverse;
        @(posedge clk_in) disable iff (!rst_n_in)
        !cfg_power_down_in |=> foldback_out == !$past(pt[cfg_idx_fold_in]);
    endproperty
    a_fold_inverse: assert property (p_fold_inverse) else $error("foldback not inverse");

    c_d_capture:  cover property (@(posedge clk_in) clk_rise && ce_ok && normal);
    c_clear_set:  cover property (@(posedge clk_in) clear_act && set_act);
    c_latch_open: cover property (@(posedge clk_in) cfg_ff_mode_in == FF_LATCH && clk_sel);
    c_sleep:      cover property (@(posedge clk_in) asleep);

endmodule : programmable_macrocell

/* sim/pin_driver.sv */
// Far-side model: outside circuits driving the input pins, global clocks and clear.
// Assumes the bench calls drive() only after reset has been released.
`timescale 1ns/1ps
module pin_driver (
    // Clock
    input  wire logic        clk_in,
    // Pin levels
    output logic      [31:0] pins_out,
    output logic      [2:0]  gclk_out,
    output logic             gclr_out
);
    // ==========================================
    // Clocks stay low from power-up until the first call
    initial begin
        pins_out = 32'h0000_0000;
        gclk_out = 3'h0;
        gclr_out = 1'b0;
    end

    // Hold each level 8 cycles: pins are filtered, so short pulses get lost
    task automatic drive(input logic [31:0] p, input logic [2:0] c, input logic r);
        @(posedge clk_in);
        #5;
        pins_out = p;
        gclk_out = c;
        gclr_out = r;
        repeat (8) @(posedge clk_in);
    endtask : drive
endmodule : pin_driver

/* sim/tb.sv */
// Bench for one macrocell wired as a D register fed by pin 0, later reset into T mode.
// Assumes the pin_driver model stands in for the outside circuits.
`timescale 1ns/1ps
module tb;
    import macrocell_pkg::*;
    // ==========================================
    // Signals
    logic clk_in = 1'b0, rst_n_in = 1'b0, global_clear_line_in, oe_io_pin_in, sleep_pin_in, chain_sum_in, io_in;
    logic io_out, io_oe_n_out, buried_fb_out, foldback_out, chain_sum_out, q_out, cfg_chain_en_in;
    logic [31:0] pins_in;
    logic [63:0] feedback_bus_in;
    logic [15:0] foldback_bus_in;
    logic [2:0] global_clock_line_in, cfg_idx_xor_b_in, cfg_idx_data_in, cfg_idx_aux_in, cfg_idx_clk_in;
    logic [2:0] cfg_idx_ce_in, cfg_idx_clear_in, cfg_idx_set_in, cfg_idx_oe_in, cfg_idx_fold_in;
    logic [1:0] oe_pins_in, cfg_clk_line_in;
    logic [6:0] cfg_matrix_sel_in [40];
    logic [55:0] cfg_true_mask_in [5], cfg_comp_mask_in [5];
    logic [4:0] cfg_term_to_logic_in;
    logic cfg_clk_from_term_in, cfg_clk_enable_en_in, cfg_pin_registered_in, cfg_fb_registered_in;
    logic cfg_sleep_en_in, cfg_is_sleep_pin_in, cfg_power_down_in;
    xor_b_type cfg_xor_b_in = XB_LOW;
    data_src_type cfg_data_src_in = DATA_XOR;
    ff_mode_type cfg_ff_mode_in = FF_D;
    clear_sel_type cfg_clear_sel_in = CLR_GLOBAL;
    set_sel_type cfg_set_sel_in = SET_OFF;
    oe_sel_type cfg_oe_sel_in = OE_ALWAYS;
    int n_fail = 0, num_checks = 0;

    // Undriven pin shows the inverse of the last drive value
    assign io_in = io_oe_n_out ? ~io_out : io_out;
    always #25 clk_in = ~clk_in;
    programmable_macrocell uut (.*);
    pin_driver partner (.clk_in(clk_in), .pins_out(pins_in), .gclk_out(global_clock_line_in),
                        .gclr_out(global_clear_line_in));

    // ==========================================
    // Checking and closing
    task automatic check(input logic seen, input logic exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %b want %b", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test

    // ==========================================
    // Scenarios
    task automatic t_reset();
        repeat (2) @(posedge clk_in);
        #5;
        check(q_out, 1'b0);
        check(io_oe_n_out, 1'b1);
        check(io_out, 1'b0);
        repeat (2) @(posedge clk_in);
        #5;
        rst_n_in = 1'b1;
        repeat (3) @(posedge clk_in);
        #5;
        check(io_oe_n_out, 1'b0);
        $display("t_reset done");
    endtask : t_reset

    // Only line 0 rises must move the register; line 1 is a distractor
    task automatic t_dreg();
        partner.drive(32'h0000_0001, 3'h0, 1'b0);
        check(q_out, 1'b0);
        partner.drive(32'h0000_0001, 3'h1, 1'b0);
        check(q_out, 1'b1);
        check(io_out, 1'b1);
        check(buried_fb_out, 1'b1);
        check(foldback_out, 1'b0);
        check(chain_sum_out, 1'b1);
        partner.drive(32'h0000_0000, 3'h2, 1'b0);
        check(q_out, 1'b1);
        check(foldback_out, 1'b1);
        check(chain_sum_out, 1'b0);
        partner.drive(32'h0000_0000, 3'h3, 1'b0);
        check(q_out, 1'b0);
        $display("t_dreg done");
    endtask : t_dreg

    task automatic t_clear();
        partner.drive(32'h0000_0001, 3'h0, 1'b0);
        partner.drive(32'h0000_0001, 3'h1, 1'b0);
        partner.drive(32'h0000_0001, 3'h1, 1'b1);
        check(q_out, 1'b0);
        partner.drive(32'h0000_0001, 3'h0, 1'b0);
        partner.drive(32'h0000_0001, 3'h1, 1'b0);
        check(q_out, 1'b1);
        $display("t_clear done");
    endtask : t_clear

    // Mid-run reset into T mode with inverted polarity, combinational pin and output off;
    // clock lines go low first so the fresh synchronisers see no false rise
    task automatic t_toggle();
        partner.drive(32'h0000_0000, 3'h0, 1'b0);
        #5;
        rst_n_in = 1'b0;
        cfg_xor_b_in = XB_HIGH;
        cfg_ff_mode_in = FF_T;
        cfg_oe_sel_in = OE_NEVER;
        cfg_pin_registered_in = 1'b0;
        repeat (4) @(posedge clk_in);
        #5;
        check(io_out, 1'b1);
        rst_n_in = 1'b1;
        partner.drive(32'h0000_0000, 3'h1, 1'b0);
        check(q_out, 1'b1);
        check(io_out, 1'b1);
        check(buried_fb_out, 1'b1);
        check(io_oe_n_out, 1'b1);
        partner.drive(32'h0000_0001, 3'h0, 1'b0);
        check(io_out, 1'b0);
        partner.drive(32'h0000_0000, 3'h1, 1'b0);
        check(q_out, 1'b0);
        $display("t_toggle done");
    endtask : t_toggle

    // ==========================================
    // Static setup: term 0 is pin 0 through block input 0
    initial begin
        {feedback_bus_in, foldback_bus_in, oe_pins_in, oe_io_pin_in, sleep_pin_in, chain_sum_in} = '0;
        {cfg_idx_xor_b_in, cfg_idx_data_in, cfg_idx_aux_in, cfg_idx_clk_in, cfg_idx_ce_in} = '0;
        {cfg_idx_clear_in, cfg_idx_set_in, cfg_idx_oe_in, cfg_idx_fold_in, cfg_clk_line_in} = '0;
        {cfg_chain_en_in, cfg_clk_from_term_in, cfg_clk_enable_en_in, cfg_sleep_en_in} = '0;
        {cfg_is_sleep_pin_in, cfg_power_down_in} = '0;
        {cfg_pin_registered_in, cfg_fb_registered_in} = 2'h3;
        cfg_term_to_logic_in = 5'h01;
        foreach (cfg_matrix_sel_in[i]) cfg_matrix_sel_in[i] = (i == 0) ? 7'h00 : 7'h7F;
        foreach (cfg_true_mask_in[i]) cfg_true_mask_in[i] = (i == 0) ? 56'h1 : 56'h0;
        foreach (cfg_comp_mask_in[i]) cfg_comp_mask_in[i] = 56'h0;
        t_reset();
        t_dreg();
        t_clear();
        t_toggle();
        end_of_test();
    end

    // Watchdog: the tests need about 6 us
    initial begin
        #50_000;
        n_fail++;
        end_of_test();
    end
endmodule : tb
